// >>> hw/startup_pkg.sv
/*
  Shared constants for the transceiver start-up sequencer and its host end.
  Assumes a single 20 MHz mclk on both ends.
*/
package startup_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_US = 2000;
  localparam int RESET_MIN_CYC = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLL_CAL_MAX_US = 700;
  localparam int DLL_CAL_MAX_CYC = (DLL_CAL_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int OSC_START_DEFAULT = 64;
  localparam int DLL_CAL_DEFAULT = 1000;
  // Host margin for the device reset sync and oscillator start
  localparam int SYNC_SETTLE_CYC = 8;
  localparam int CNT_W = 17;
  // ==========================================================
  // Link command codes
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_FW_WORD = 3'h1;
  localparam logic [2:0] CMD_FW_DONE = 3'h2;
  localparam logic [2:0] CMD_DLL_CAL = 3'h3;
  localparam logic [2:0] CMD_POLL = 3'h4;
  localparam logic [2:0] CMD_REFCLK_EN = 3'h5;
  // ==========================================================
  // Status word bits
  localparam int ST_OSC_OK = 0;
  localparam int ST_FW_LOADED = 1;
  localparam int ST_CAL_DONE = 2;
  localparam int ST_REFCLK_ON = 3;
  localparam int ST_W = 4;
  localparam logic [ST_W-1:0] ST_RESET = 4'h0;
  // ==========================================================
  // Configuration path selection
  localparam logic PATH_TWO_WIRE = 1'b0;
  localparam logic PATH_SERIAL = 1'b1;
  localparam int SERIAL_BOOT_MBPS = 100;

  typedef enum logic [2:0] {
    DEV_OSC_WAIT = 3'b000,
    DEV_CONFIG   = 3'b001,
    DEV_CALIB    = 3'b011,
    DEV_READY    = 3'b010,
    DEV_REFCLK   = 3'b110
  } dev_state_t;

  typedef enum logic [2:0] {
    HOST_RESET   = 3'b000,
    HOST_LOAD    = 3'b001,
    HOST_CAL     = 3'b011,
    HOST_POLL    = 3'b010,
    HOST_ENABLE  = 3'b110,
    HOST_DONE    = 3'b111
  } host_state_t;
endpackage : startup_pkg

// >>> hw/startup_if.sv
/*
  Link between the baseband host and the transceiver start-up block.
  Assumes both ends share mclk; the testbench joins the two modules here.
*/
`timescale 1ns/100ps
interface startup_if;
  import startup_pkg::*;
  logic reset_n;
  logic cmd_valid;
  logic [2:0] cmd_code;
  logic [7:0] cmd_data;
  logic cmd_path;
  logic rsp_valid;
  logic [ST_W-1:0] rsp_status;
  logic cal_busy;

  modport device (
    input reset_n, cmd_valid, cmd_code, cmd_data, cmd_path,
    output rsp_valid, rsp_status, cal_busy
  );
  modport host (
    output reset_n, cmd_valid, cmd_code, cmd_data, cmd_path,
    input rsp_valid, rsp_status, cal_busy
  );
endinterface : startup_if

// >>> hw/transceiver_startup_sequencer.sv
/*
  Device end: start-up sequencer of the transceiver digital core.
  Assumes reset_n arrives from a pin; oscillator and DLL are modelled by counters.
*/
// Summary of operation
// - Core held in async reset while reset_n low
// - Host holds reset until supplies stable
// - Host holds reset at least 2 ms
// - External clock: release only when clock good
// - Oscillator enabled by reset values
// - Reference clock output tri-stated after reset
// - 20 MHz oscillator clock distributed for configuration
// - Configuration over two-wire or serial link
// - Calibration completion reported in polled status
// - DLL calibration completes within 700 us
// - Host enables reference clock after calibration
`timescale 1ns/100ps
module transceiver_startup_sequencer
  import startup_pkg::*;
#(
  parameter int OSC_START_CYC = OSC_START_DEFAULT,
  parameter int DLL_CAL_CYC = DLL_CAL_DEFAULT
) (
  // Clock and board reset
  input wire logic mclk,
  input wire logic reset,
  // Host link
  startup_if.device link,
  // Analog controls
  output logic crystal_oscillator_en,
  output logic osc_regulator_en,
  output logic core_clk_en,
  output logic reference_clock_output_oe,
  output logic reference_clock_output_run,
  // Firmware write port
  output logic fw_we,
  output logic [7:0] fw_data
);
  // ==========================================================
  // Reset pin: asserts at once, releases through sync
  logic rst_n_s1, rst_n_s2, rst_n_s3;
  logic core_rst;
  always_ff @(posedge mclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      rst_n_s1 <= 1'b0;
      rst_n_s2 <= 1'b0;
      rst_n_s3 <= 1'b0;
    end else begin
      rst_n_s1 <= 1'b1;
      rst_n_s2 <= rst_n_s1;
      rst_n_s3 <= rst_n_s2;
    end
  end
  // Release counts only when the last two stages agree
  assign core_rst = reset | !(rst_n_s2 & rst_n_s3);

  // ==========================================================
  // Sequencer
  dev_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [ST_W-1:0] status_reg;
  logic cal_timeout;
  assign cal_timeout = (cnt_reg >= CNT_W'(DLL_CAL_MAX_CYC - 1)) ||
                       (cnt_reg >= CNT_W'(DLL_CAL_CYC - 1));

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      state_reg <= DEV_OSC_WAIT;
      cnt_reg <= '0;
      status_reg <= ST_RESET;
    end else begin
      unique case (state_reg)
        DEV_OSC_WAIT: begin
          // Oscillator already running from reset values
          if (cnt_reg >= CNT_W'(OSC_START_CYC - 1)) begin
            state_reg <= DEV_CONFIG;
            cnt_reg <= '0;
            status_reg[ST_OSC_OK] <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        DEV_CONFIG: begin
          if (link.cmd_valid && link.cmd_code == CMD_FW_DONE) begin
            status_reg[ST_FW_LOADED] <= 1'b1;
          end
          // Calibration ignored until firmware is in
          if (link.cmd_valid && link.cmd_code == CMD_DLL_CAL && status_reg[ST_FW_LOADED]) begin
            state_reg <= DEV_CALIB;
            cnt_reg <= '0;
          end
        end
        DEV_CALIB: begin
          // Capped at the 700 us bound whatever the model says
          if (cal_timeout) begin
            state_reg <= DEV_READY;
            status_reg[ST_CAL_DONE] <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        DEV_READY: begin
          if (link.cmd_valid && link.cmd_code == CMD_REFCLK_EN) begin
            state_reg <= DEV_REFCLK;
            status_reg[ST_REFCLK_ON] <= 1'b1;
          end
        end
        DEV_REFCLK: begin
          state_reg <= DEV_REFCLK;
        end
        default: begin
          state_reg <= DEV_OSC_WAIT;
        end
      endcase
    end
  end

  // ==========================================================
  // Oscillator and regulator enables
  // Held on in and out of reset so the clock never stops
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      crystal_oscillator_en <= 1'b1;
    end else begin
      crystal_oscillator_en <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      osc_regulator_en <= 1'b1;
    end else begin
      osc_regulator_en <= 1'b1;
    end
  end

  // ==========================================================
  // Core clock gate
  // Opens only once the oscillator start count has run out
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      core_clk_en <= 1'b0;
    end else begin
      core_clk_en <= status_reg[ST_OSC_OK];
    end
  end

  // ==========================================================
  // Reference clock output
  // Buffer stays tri-stated until the enable command lands
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      reference_clock_output_oe <= 1'b0;
    end else begin
      reference_clock_output_oe <= status_reg[ST_REFCLK_ON];
    end
  end

  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      reference_clock_output_run <= 1'b0;
    end else begin
      reference_clock_output_run <= status_reg[ST_REFCLK_ON];
    end
  end

  // ==========================================================
  // Firmware write port
  // Either path may carry firmware; both share one decoder
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      fw_we <= 1'b0;
    end else begin
      fw_we <= link.cmd_valid && link.cmd_code == CMD_FW_WORD &&
               state_reg == DEV_CONFIG && !status_reg[ST_FW_LOADED];
    end
  end

  // Data follows the link every cycle; only fw_we qualifies it
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      fw_data <= 8'h00;
    end else begin
      fw_data <= link.cmd_data;
    end
  end

  // ==========================================================
  // Poll answer
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.rsp_valid <= 1'b0;
    end else begin
      link.rsp_valid <= link.cmd_valid && link.cmd_code == CMD_POLL;
    end
  end

  // Status is refreshed every cycle, not only on a poll
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.rsp_status <= ST_RESET;
    end else begin
      link.rsp_status <= status_reg;
    end
  end

  // ==========================================================
  // Calibration busy
  // Lags the state by one cycle, like every other output
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.cal_busy <= 1'b0;
    end else begin
      link.cal_busy <= state_reg == DEV_CALIB;
    end
  end
endmodule : transceiver_startup_sequencer

// >>> hw/startup_host.sv
/*
  Host end: baseband controller that resets, loads and starts the transceiver.
  Assumes the device end answers polls one cycle after the request.
*/
`timescale 1ns/100ps
module startup_host
  import startup_pkg::*;
#(
  parameter int RESET_HOLD_CYC = RESET_MIN_CYC,
  parameter int FW_WORDS = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // User side
  input wire logic start,
  input wire logic use_serial,
  input wire logic clock_good,
  output logic busy,
  output logic done,
  // Device link
  startup_if.host link
);
  // ==========================================================
  // Sequencer
  host_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic poll_wait_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= HOST_RESET;
      cnt_reg <= '0;
      poll_wait_reg <= 1'b0;
      link.reset_n <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= CMD_NONE;
      link.cmd_data <= 8'h00;
      link.cmd_path <= PATH_TWO_WIRE;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      link.cmd_valid <= 1'b0;
      link.cmd_code <= CMD_NONE;
      unique case (state_reg)
        HOST_RESET: begin
          link.reset_n <= 1'b0;
          busy <= start | busy;
          if (cnt_reg < CNT_W'(RESET_HOLD_CYC)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else if (clock_good && (start || busy)) begin
            link.reset_n <= 1'b1;
            // Serial boot sends one command per cycle, the same rate as two-wire
            link.cmd_path <= use_serial ? PATH_SERIAL : PATH_TWO_WIRE;
            cnt_reg <= '0;
            state_reg <= HOST_LOAD;
          end
        end
        HOST_LOAD: begin
          // Allow device oscillator and sync to settle first
          if (cnt_reg < CNT_W'(OSC_START_DEFAULT + SYNC_SETTLE_CYC)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end else if (cnt_reg < CNT_W'(OSC_START_DEFAULT + SYNC_SETTLE_CYC + FW_WORDS)) begin
            link.cmd_valid <= 1'b1;
            link.cmd_code <= CMD_FW_WORD;
            link.cmd_data <= cnt_reg[7:0];
            cnt_reg <= cnt_reg + 1'b1;
          end else begin
            link.cmd_valid <= 1'b1;
            link.cmd_code <= CMD_FW_DONE;
            state_reg <= HOST_CAL;
          end
        end
        HOST_CAL: begin
          link.cmd_valid <= 1'b1;
          link.cmd_code <= CMD_DLL_CAL;
          poll_wait_reg <= 1'b0;
          state_reg <= HOST_POLL;
        end
        HOST_POLL: begin
          if (!poll_wait_reg) begin
            link.cmd_valid <= 1'b1;
            link.cmd_code <= CMD_POLL;
            poll_wait_reg <= 1'b1;
          end else if (link.rsp_valid) begin
            poll_wait_reg <= 1'b0;
            if (link.rsp_status[ST_CAL_DONE]) begin
              state_reg <= HOST_ENABLE;
            end
          end
        end
        HOST_ENABLE: begin
          link.cmd_valid <= 1'b1;
          link.cmd_code <= CMD_REFCLK_EN;
          state_reg <= HOST_DONE;
        end
        HOST_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          state_reg <= HOST_RESET;
        end
      endcase
    end
  end
endmodule : startup_host

// >>> tb/startup_link_monitor.sv
/*
  Assertion monitor for the start-up link between host and device.
  Assumes one mclk domain; HOLD matches the host reset hold count.
*/
`timescale 1ns/100ps
module startup_link_monitor
  import startup_pkg::*;
#(
  parameter int HOLD = RESET_MIN_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Link
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic rsp_valid,
  input wire logic [ST_W-1:0] rsp_status,
  input wire logic cal_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Helpers
  int low_reg = 0;
  int busy_reg = 0;
  logic poll_reg = 1'b0;
  logic ref_reg = 1'b0;
  logic fw_seen_reg = 1'b0;
  always_ff @(posedge mclk) begin
    if (!reset_n) fw_seen_reg <= 1'b0;
    else if (cmd_valid && cmd_code == CMD_FW_DONE) fw_seen_reg <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (reset_n) low_reg <= 0;
    else low_reg <= low_reg + 1;
  end
  always_ff @(posedge mclk) begin
    if (cal_busy) busy_reg <= busy_reg + 1;
    else busy_reg <= 0;
  end
  always_ff @(posedge mclk) begin
    poll_reg <= cmd_valid && cmd_code == CMD_POLL;
    ref_reg <= cmd_valid && cmd_code == CMD_REFCLK_EN;
  end
  sequence cal_cmd_s;
    cmd_valid && cmd_code == CMD_DLL_CAL ##0
      fw_seen_reg && !rsp_status[ST_CAL_DONE] && !cal_busy;
  endsequence
  sequence poll_s;
    cmd_valid && cmd_code == CMD_POLL ##0 rsp_status[ST_OSC_OK];
  endsequence
  // ==========================================================
  // Properties
  AST_ASYNC_CLEAR: assert property (!reset_n |-> rsp_status == ST_RESET && !cal_busy)
    else $error("status not cleared while reset_n low");
  AST_HOLD: assert property ($rose(reset_n) |-> low_reg >= HOLD)
    else $error("reset_n released too early");
  AST_POLL_ANS: assert property (poll_s |=> rsp_valid)
    else $error("poll not answered");
  AST_ANS_CAUSE: assert property (rsp_valid |-> poll_reg)
    else $error("answer without poll");
  AST_CAL_START: assert property (cal_cmd_s |-> ##2 cal_busy)
    else $error("calibration did not start");
  AST_CAL_GATE: assert property ($rose(cal_busy) |-> rsp_status[ST_FW_LOADED])
    else $error("calibration before firmware");
  AST_CAL_BOUND: assert property (busy_reg <= DLL_CAL_MAX_CYC)
    else $error("calibration too long");
  AST_CAL_REPORT: assert property ($fell(cal_busy) && reset_n |-> ##[0:1] rsp_status[ST_CAL_DONE])
    else $error("calibration end not reported");
  AST_REF_GATE: assert property ($rose(rsp_status[ST_REFCLK_ON]) |-> $past(ref_reg) && rsp_status[ST_CAL_DONE])
    else $error("reference clock on without command after calibration");
endmodule : startup_link_monitor

// >>> tb/test_transceiver_startup_sequencer.sv
/*
  Testbench joining host and device ends over the link.
  Assumes short hold, oscillator and calibration counts for simulation.
*/
`timescale 1ns/100ps
module test_transceiver_startup_sequencer
  import startup_pkg::*;
;
  localparam int HOLD = 50;
  localparam int FW_N = 4;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic use_serial = 1'b0;
  logic clock_good = 1'b0;
  logic done, xo_en, reg_en, core_en, ref_oe, ref_run, fw_we, host_busy;
  logic [7:0] fw_data;
  logic [7:0] fw_last = 8'h00;
  int miscompares = 0;
  int checks = 0;
  int fw_cnt = 0;
  int path_bad = 0;
  startup_if link ();
  always #25 mclk = ~mclk;
  transceiver_startup_sequencer #(.OSC_START_CYC(16), .DLL_CAL_CYC(40))
    u_transceiver_startup_sequencer (.mclk(mclk), .reset(reset), .link(link.device),
    .crystal_oscillator_en(xo_en), .osc_regulator_en(reg_en), .core_clk_en(core_en),
    .reference_clock_output_oe(ref_oe), .reference_clock_output_run(ref_run),
    .fw_we(fw_we), .fw_data(fw_data));
  startup_host #(.RESET_HOLD_CYC(HOLD), .FW_WORDS(FW_N)) u_startup_host (.mclk(mclk),
    .reset(reset), .start(start), .use_serial(use_serial), .clock_good(clock_good),
    .busy(host_busy), .done(done), .link(link.host));
  startup_link_monitor #(.HOLD(HOLD)) u_startup_link_monitor (.mclk(mclk), .reset(reset),
    .reset_n(link.reset_n), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
    .rsp_valid(link.rsp_valid), .rsp_status(link.rsp_status), .cal_busy(link.cal_busy));
  always @(posedge mclk) begin
    if (fw_we) fw_cnt <= fw_cnt + 1;
    if (fw_we) fw_last <= fw_data;
    if (link.cmd_valid && link.cmd_path !== use_serial) path_bad <= path_bad + 1;
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Bounded wait: cal_busy when sel, else done
  task wait_hi(input bit sel);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(posedge mclk);
      if (sel ? link.cal_busy === 1'b1 : done === 1'b1) break;
    end
    if (i == 20000) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_hi
  task pulse_start;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
  endtask : pulse_start
  // Full boot; clock held bad first so release must wait for it
  task boot(input logic serial);
    int f0;
    f0 = fw_cnt;
    use_serial <= serial;
    clock_good <= 1'b0;
    pulse_start();
    cyc(200);
    chk(32'(link.reset_n), 32'h0);
    chk(32'({xo_en, reg_en, ref_oe}), 32'h6);
    clock_good <= 1'b1;
    pulse_start();
    wait_hi(1'b1);
    chk(fw_cnt - f0, FW_N);
    chk(32'(fw_last), 32'(OSC_START_DEFAULT + SYNC_SETTLE_CYC + FW_N - 1));
    chk(32'(host_busy), 32'h1);
    chk(32'({core_en, ref_oe}), 32'h2);
    wait_hi(1'b0);
    cyc(3);
    chk(32'(link.rsp_status), 32'hF);
    chk(32'({ref_oe, ref_run}), 32'h3);
    chk(32'(host_busy), 32'h0);
    chk(path_bad, 0);
  endtask : boot
  // ==========================================================
  // Main sequence
  initial begin
    cyc(10);
    reset <= 1'b0;
    boot(1'b0);
    // Reset from the running state must leave status cleared and the clock output off, checked 3 cycles after release
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(3);
    chk(32'(link.rsp_status), 32'(ST_RESET));
    chk(32'({link.reset_n, ref_oe}), 32'h0);
    boot(1'b1);
    finish_test();
  end
endmodule : test_transceiver_startup_sequencer
